/* File: logic/rbiv_regs.vh */
`ifndef RBIV_REGS_VH
`define RBIV_REGS_VH
`define RBIV_ADDR_CHIP_CTRL  8'h9F
`define RBIV_ADDR_BOOT_CFG   8'hA0
`define RBIV_ADDR_IRQ_EN     8'hA1
`define RBIV_ADDR_IRQ_CTRL   8'hA2
`define RBIV_ADDR_IRQ_STAT   8'hA3
`define RBIV_ADDR_IRQ_MASK   8'hA4
`define RBIV_ADDR_PRIO_SEL   8'hA5
`define RBIV_ADDR_PRIO_VAL   8'hA6
`define RBIV_ADDR_STATE      8'hA7
`define RBIV_BIT_SOFT_RST    7
`define RBIV_BIT_BOOT_SRC    1
`define RBIV_BIT_CFG_BOOT    7
`define RBIV_BIT_GIE         7
`define RBIV_CFG_FACTORY     8'hFF
`define RBIV_RESET_PC        16'h0000
`define RBIV_RESET_SP        8'h07
`define RBIV_PORT_RESET      8'hFF
`define RBIV_VEC_BASE        16'h0003
`define RBIV_VEC_STEP_SH     3
`define RBIV_NSRC            30
`define RBIV_NLVL            4
`endif

/* File: logic/rbiv_vec_gen.v */
`timescale 1ns/100ps
`include "rbiv_regs.vh"
// Vector address for a source number
module rbiv_vec_gen (
    input  wire [4:0]  src_num,
    output wire [15:0] vec_addr
);
    wire [15:0] ext_num;
    assign ext_num  = {11'h000, src_num};
    assign vec_addr = `RBIV_VEC_BASE + (ext_num << `RBIV_VEC_STEP_SH); // see (RULE19) (RULE14) (RULE15)
endmodule // rbiv_vec_gen

/* File: logic/rbiv_arbiter.v */
`timescale 1ns/100ps
`include "rbiv_regs.vh"
// Picks the highest level, then the lowest source number within a level
module rbiv_arbiter #(
    parameter NSRC = `RBIV_NSRC
) (
    input  wire [NSRC-1:0]   req,
    input  wire [2*NSRC-1:0] prio,
    output reg               found,
    output reg  [4:0]        win_num,
    output reg  [1:0]        win_lvl
);
    integer i;
    always @* begin
        found   = 1'b0;
        win_num = 5'h00;
        win_lvl = 2'h0;
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (req[i] && (!found || prio[2*i +: 2] >= win_lvl)) begin // see (RULE18)
                found   = 1'b1;
                win_num = i[4:0];
                win_lvl = prio[2*i +: 2];
            end
        end
    end
endmodule // rbiv_arbiter

/* File: logic/rbiv_core.v */
`timescale 1ns/100ps
`include "rbiv_regs.vh"
// How it works
// (RULE1) Config byte bit 7: one boots application ROM, zero boots loader ROM.
// (RULE2) Config byte comes out of the factory as all ones.
// (RULE3) Chip control bit 1 picks boot block: zero application, one loader.
// (RULE4) Non-software resets load boot source with inverted config bit.
// (RULE5) Only power-on reset may disturb RAM; others keep it.
// (RULE6) Program counter is held at zero during any reset.
// (RULE7) Every reset sets the stack pointer to seven.
// (RULE8) Reset disables peripherals and interrupts, port latches all ones, inputs.
// (RULE9) Registers take reset values; event-dependent bits follow their own rules.
// (RULE10) Thirty sources, four levels, per-source enable, level, vector, global.
// (RULE11) A taken interrupt loads its vector and enters in-service state.
// (RULE12) Only a strictly higher level may preempt a running handler.
// (RULE13) Return ends in-service and resumes the interrupted instruction.
// (RULE14) Sources zero to eight sit at 0003H through 0043H.
// (RULE15) Sources nine to seventeen sit at 004BH through 008BH.
// (RULE16) Writing one to chip control bit 7 starts a soft reset, self-clearing.
// (RULE17) Global enable low blocks all; requests stay pending until set.
// (RULE18) Higher level first; equal levels go by fixed natural order.
// (RULE19) Vector for source n is 0003H plus eight times n.
module rbiv_core #(
    parameter NSRC = `RBIV_NSRC
) (
    input  wire            mclk,
    input  wire            sys_rst,
    input  wire            clk_en,
    input  wire            por_rst,
    input  wire            ext_rst,
    input  wire            wdt_rst,
    input  wire            fault_rst,
    input  wire [7:0]      bus_addr,
    input  wire [7:0]      bus_wdata,
    input  wire            bus_wr,
    input  wire            bus_rd,
    output reg  [7:0]      bus_rdata,
    input  wire [NSRC-1:0] irq_req,
    input  wire            reti,
    input  wire            fetch_adv,
    input  wire [15:0]     next_pc,
    output reg  [15:0]     pc_out,
    output reg             pc_load,
    output reg  [7:0]      sp_out,
    output reg             in_reset,
    output reg             ram_keep,
    output reg             boot_loader,
    output reg  [7:0]      port_latch,
    output reg             port_input_only,
    output reg             periph_enable,
    output reg             irq_out
);
    // Three-stage sync of external reset sources
    reg  [3:0] rs1_ff;
    reg  [3:0] rs2_ff;
    reg  [3:0] rs3_ff;
    reg  [3:0] rsq_ff;
    reg  [7:0] cfg_ff;
    reg        boot_src_ff;
    reg        soft_req_ff;
    reg        soft_run_ff;
    reg        gie_ff;
    reg  [NSRC-1:0]   en_ff;
    reg  [NSRC-1:0]   pend_ff;
    reg  [2*NSRC-1:0] prio_ff;
    reg  [4:0] prio_sel_ff;
    reg  [4:0] en_sel_ff;
    reg  [2:0] depth_ff;
    reg  [1:0] lvl_stk_ff [0:3];
    reg  [15:0] ret_stk_ff [0:3];
    reg  [1:0] stat_ff;
    reg  [1:0] mask_ff;
    wire [3:0] rs_now;
    wire       any_hw_rst;
    wire       any_rst;
    wire       arb_found;
    wire [4:0] arb_num;
    wire [1:0] arb_lvl;
    wire [15:0] vec_addr;
    wire [1:0] cur_lvl;
    wire       take;
    wire [NSRC-1:0] gated;
    wire       ret_ok;
    reg  [7:0] nxt_rdata;
    integer    k;
    wire [NSRC-1:0] nxt_pend;
    wire [1:0] stat_evt;
    wire       en_sel_ok;
    wire       prio_sel_ok;
    wire       wr_cc;
    wire       wr_cfg;
    wire       rd_stat;
    wire       wr_mask;
    wire       irq_lvl;
    genvar     g;
    localparam [7:0] CFG_FACTORY = `RBIV_CFG_FACTORY;

    always @(posedge mclk) begin
        if (sys_rst) begin
            rs1_ff <= 4'h0;
            rs2_ff <= 4'h0;
            rs3_ff <= 4'h0;
            rsq_ff <= 4'h0;
        end else if (clk_en) begin
            rs1_ff <= {fault_rst, wdt_rst, ext_rst, por_rst};
            rs2_ff <= rs1_ff;
            rs3_ff <= rs2_ff;
            if (rs2_ff == rs3_ff) begin
                rsq_ff <= rs3_ff;
            end
        end
    end

    assign rs_now     = rsq_ff;
    assign any_hw_rst = sys_rst | (|rs_now);
    assign any_rst    = any_hw_rst | soft_run_ff;
    assign gated      = pend_ff & en_ff & {NSRC{gie_ff}}; // see (RULE17) (RULE10)
    assign cur_lvl    = (depth_ff == 3'h0) ? 2'h0 : lvl_stk_ff[depth_ff[1:0] - 2'h1];
    assign take       = arb_found && !any_rst && fetch_adv && depth_ff < 3'h4
                        && (depth_ff == 3'h0 || arb_lvl > cur_lvl); // see (RULE12)
    assign ret_ok     = reti && depth_ff != 3'h0 && !any_rst;
    assign en_sel_ok   = (en_sel_ff < NSRC);
    assign prio_sel_ok = (prio_sel_ff < NSRC);
    assign wr_cc       = bus_wr && (bus_addr == `RBIV_ADDR_CHIP_CTRL);
    assign wr_cfg      = bus_wr && (bus_addr == `RBIV_ADDR_BOOT_CFG);
    assign rd_stat     = bus_rd && (bus_addr == `RBIV_ADDR_IRQ_STAT);
    assign wr_mask     = bus_wr && (bus_addr == `RBIV_ADDR_IRQ_MASK);
    assign stat_evt    = {soft_run_ff, take};
    assign irq_lvl     = |(stat_ff & mask_ff);

    // Pending bits: a new request wins over clearing a taken one
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_pend
            assign nxt_pend[g] = irq_req[g]
                                 | (pend_ff[g] & ~(take && arb_num == g));
        end
    endgenerate

    rbiv_arbiter #(.NSRC(NSRC)) u_arb (
        .req     (gated),
        .prio    (prio_ff),
        .found   (arb_found),
        .win_num (arb_num),
        .win_lvl (arb_lvl)
    );

    rbiv_vec_gen u_vec (
        .src_num  (arb_num),
        .vec_addr (vec_addr)
    );

    // Boot selection and soft reset
    always @(posedge mclk) begin
        if (sys_rst || rs_now[0]) begin
            cfg_ff <= `RBIV_CFG_FACTORY; // see (RULE2)
        end else if (clk_en && wr_cfg) begin
            cfg_ff <= bus_wdata;
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            boot_src_ff <= ~CFG_FACTORY[`RBIV_BIT_CFG_BOOT]; // see (RULE4)
            soft_req_ff <= 1'b0;
            soft_run_ff <= 1'b0;
        end else if (clk_en) begin
            if (|rs_now) begin
                boot_src_ff <= ~cfg_ff[`RBIV_BIT_CFG_BOOT]; // see (RULE4) (RULE1)
                soft_req_ff <= 1'b0;
                soft_run_ff <= 1'b0;
            end else if (soft_run_ff) begin
                soft_run_ff <= 1'b0; // boot_src kept, see (RULE4)
                soft_req_ff <= 1'b0; // see (RULE16)
            end else if (soft_req_ff) begin
                soft_run_ff <= 1'b1;
            end else if (wr_cc) begin
                boot_src_ff <= bus_wdata[`RBIV_BIT_BOOT_SRC]; // see (RULE3)
                soft_req_ff <= bus_wdata[`RBIV_BIT_SOFT_RST]; // see (RULE16)
            end
        end
    end

    // Interrupt configuration: enables, levels and selectors
    always @(posedge mclk) begin
        if (any_rst) begin
            gie_ff      <= 1'b0; // see (RULE8) (RULE9)
            en_ff       <= {NSRC{1'b0}};
            prio_ff     <= {2*NSRC{1'b0}};
            prio_sel_ff <= 5'h00;
            en_sel_ff   <= 5'h00;
        end else if (clk_en) begin
            if (bus_wr) begin
                case (bus_addr)
                `RBIV_ADDR_IRQ_CTRL: begin
                    gie_ff    <= bus_wdata[`RBIV_BIT_GIE];
                    en_sel_ff <= bus_wdata[4:0];
                end
                `RBIV_ADDR_IRQ_EN: begin
                    if (en_sel_ok) begin
                        en_ff[en_sel_ff] <= bus_wdata[0]; // see (RULE10)
                    end
                end
                `RBIV_ADDR_PRIO_SEL: begin
                    prio_sel_ff <= bus_wdata[4:0];
                end
                `RBIV_ADDR_PRIO_VAL: begin
                    if (prio_sel_ok) begin
                        prio_ff[2*prio_sel_ff +: 2] <= bus_wdata[1:0];
                    end
                end
                default: ;
                endcase
            end
        end
    end

    // Pending requests survive a disabled global enable
    always @(posedge mclk) begin
        if (any_rst) begin
            pend_ff <= {NSRC{1'b0}};
        end else if (clk_en) begin
            pend_ff <= nxt_pend; // see (RULE17)
        end
    end

    // In-service nesting and program counter
    always @(posedge mclk) begin
        if (any_rst) begin
            depth_ff <= 3'h0;
            pc_out   <= `RBIV_RESET_PC; // see (RULE6)
            pc_load  <= 1'b1;
            for (k = 0; k < 4; k = k + 1) begin
                lvl_stk_ff[k] <= 2'h0;
                ret_stk_ff[k] <= 16'h0000;
            end
        end else if (clk_en) begin
            pc_load <= 1'b0;
            if (take) begin
                lvl_stk_ff[depth_ff[1:0]] <= arb_lvl;
                ret_stk_ff[depth_ff[1:0]] <= next_pc;
                depth_ff <= depth_ff + 3'h1;
                pc_out   <= vec_addr; // see (RULE11)
                pc_load  <= 1'b1;
            end else if (ret_ok) begin
                depth_ff <= depth_ff - 3'h1; // see (RULE13)
                pc_out   <= ret_stk_ff[depth_ff[1:0] - 2'h1];
                pc_load  <= 1'b1;
            end
        end
    end

    // Reset-state outputs
    always @(posedge mclk) begin
        if (sys_rst) begin
            sp_out          <= `RBIV_RESET_SP;
            in_reset        <= 1'b1;
            ram_keep        <= 1'b0;
            boot_loader     <= 1'b0;
            port_latch      <= `RBIV_PORT_RESET;
            port_input_only <= 1'b1;
            periph_enable   <= 1'b0;
        end else if (clk_en) begin
            in_reset    <= any_rst;
            ram_keep    <= ~rs_now[0]; // see (RULE5)
            boot_loader <= boot_src_ff; // see (RULE3)
            if (any_rst) begin
                sp_out          <= `RBIV_RESET_SP; // see (RULE7)
                port_latch      <= `RBIV_PORT_RESET; // see (RULE8)
                port_input_only <= 1'b1;
                periph_enable   <= 1'b0;
            end else begin
                periph_enable <= 1'b1;
            end
        end
    end

    // Status: bit0 interrupt taken, bit1 soft reset; clear on read
    always @(posedge mclk) begin
        if (sys_rst) begin
            stat_ff <= 2'h0;
            mask_ff <= 2'h0;
            irq_out <= 1'b0;
        end else if (clk_en) begin
            if (rd_stat) begin
                stat_ff <= stat_evt;
            end else begin
                stat_ff <= stat_ff | stat_evt;
            end
            if (wr_mask) begin
                mask_ff <= bus_wdata[1:0];
            end
            irq_out <= irq_lvl;
        end
    end

    always @* begin
        nxt_rdata = 8'h00;
        case (bus_addr)
        `RBIV_ADDR_CHIP_CTRL: nxt_rdata = {6'h00, boot_src_ff, 1'b0};
        `RBIV_ADDR_BOOT_CFG:  nxt_rdata = cfg_ff;
        `RBIV_ADDR_IRQ_CTRL:  nxt_rdata = {gie_ff, 2'h0, en_sel_ff};
        `RBIV_ADDR_IRQ_EN: begin
            if (en_sel_ok) begin
                nxt_rdata = {7'h00, en_ff[en_sel_ff]};
            end
        end
        `RBIV_ADDR_IRQ_STAT:  nxt_rdata = {6'h00, stat_ff};
        `RBIV_ADDR_IRQ_MASK:  nxt_rdata = {6'h00, mask_ff};
        `RBIV_ADDR_PRIO_SEL:  nxt_rdata = {3'h0, prio_sel_ff};
        `RBIV_ADDR_PRIO_VAL: begin
            if (prio_sel_ok) begin
                nxt_rdata = {6'h00, prio_ff[2*prio_sel_ff +: 2]};
            end
        end
        `RBIV_ADDR_STATE:     nxt_rdata = {3'h0, depth_ff, cur_lvl};
        default:              nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
        end else if (clk_en) begin
            bus_rdata <= bus_rd ? nxt_rdata : 8'h00;
        end
    end
endmodule // rbiv_core

/* File: test/rbiv_core_monitor.sv */
`timescale 1ns/100ps
module rbiv_core_monitor (
    input wire        mclk,
    input wire        sys_rst,
    input wire [7:0]  bus_addr,
    input wire [7:0]  bus_wdata,
    input wire        bus_wr,
    input wire        reti,
    input wire [15:0] pc_out,
    input wire        pc_load,
    input wire [7:0]  sp_out,
    input wire        in_reset,
    input wire        boot_loader,
    input wire [7:0]  port_latch,
    input wire        port_input_only,
    input wire        periph_enable,
    input wire        irq_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire cc_wr = bus_wr && (bus_addr == 8'h9F);
    property p_rst_core;
        $fell(sys_rst) |-> pc_out == 16'h0000 && pc_load && sp_out == 8'h07;
    endproperty
    a_rst_core: assert property (p_rst_core)
        else $error("core state after reset wrong");
    property p_rst_port;
        $fell(sys_rst) |-> port_latch == 8'hFF && port_input_only
            && !periph_enable && !irq_out;
    endproperty
    a_rst_port: assert property (p_rst_port)
        else $error("port state after reset wrong");
    property p_rst_boot;
        $fell(sys_rst) |-> !boot_loader;
    endproperty
    a_rst_boot: assert property (p_rst_boot)
        else $error("boot source after reset wrong");
    property p_hold;
        in_reset |-> pc_out == 16'h0000 && pc_load && sp_out == 8'h07;
    endproperty
    a_hold: assert property (p_hold)
        else $error("pc not held during reset");
    property p_vec;
        pc_load && !in_reset && !$past(in_reset) && !$past(reti)
            |-> pc_out[2:0] == 3'h3 && pc_out <= 16'h00EB;
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector address off grid");
    property p_ret;
        reti |=> pc_load;
    endproperty
    a_ret: assert property (p_ret)
        else $error("no pc load after return");
    property p_soft;
        cc_wr && bus_wdata[7] |-> ##[1:4] in_reset;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset not started");
    property p_soft_bs;
        cc_wr && bus_wdata[7] && bus_wdata[1] == boot_loader
            |=> $stable(boot_loader) [*6];
    endproperty
    a_soft_bs: assert property (p_soft_bs)
        else $error("soft reset changed boot source");
    property p_bs_wr;
        cc_wr && !bus_wdata[7] |=> ##1 boot_loader == $past(bus_wdata[1], 2);
    endproperty
    a_bs_wr: assert property (p_bs_wr)
        else $error("boot source write lost");
    c_soft: cover property (cc_wr && bus_wdata[7]);
    c_vec: cover property (pc_load && !in_reset);
    c_irq: cover property (irq_out);
endmodule // rbiv_core_monitor

bind rbiv_core rbiv_core_monitor u_mon (.*);

/* File: test/rbiv_cpu_model.sv */
`timescale 1ns/100ps
// Core side: follows pc loads, returns on request, stalls on request
module rbiv_cpu_model (
    input  wire        mclk,
    input  wire        stall,
    input  wire        do_ret,
    input  wire [15:0] pc_out,
    input  wire        pc_load,
    output reg         fetch_adv = 1'h0,
    output reg         reti = 1'h0,
    output reg  [15:0] next_pc = 16'h0000
);
    always @(posedge mclk) begin
        fetch_adv <= !stall;
        reti <= do_ret;
        if (pc_load) begin
            next_pc <= pc_out + 16'h0001;
        end
    end
endmodule // rbiv_cpu_model

/* File: test/rbiv_core_tb.sv */
`timescale 1ns/100ps
module rbiv_core_tb;
    reg         mclk = 1'h0;
    reg         sys_rst = 1'h1;
    reg         wdt_rst = 1'h0;
    reg         por_rst = 1'h0;
    reg  [7:0]  bus_addr = 8'h00;
    reg  [7:0]  bus_wdata = 8'h00;
    reg         bus_wr = 1'h0;
    reg         bus_rd = 1'h0;
    reg  [29:0] irq_req = 30'h0;
    reg         stall = 1'h1;
    reg         do_ret = 1'h0;
    reg         rd_d = 1'h0;
    reg  [15:0] npc = 16'h0001;
    reg  [7:0]  v;
    reg  [16:0] e;
    wire [15:0] next_pc, pc_out;
    wire [7:0]  bus_rdata, sp_out, port_latch;
    wire        fetch_adv, reti, pc_load, in_reset, ram_keep, boot_loader;
    wire        port_input_only, periph_enable, irq_out;
    int         err_count = 0, checks_done = 0, cyc = 0;
    logic [16:0] pq[$];
    logic [7:0]  rq[$];
    logic [15:0] rs[$];
    rbiv_core dut (.*, .clk_en(1'h1), .ext_rst(1'h0), .fault_rst(1'h0));
    rbiv_cpu_model cpu (.*);
    always #5 mclk = ~mclk;
    task stop_test;
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input string nm, input [15:0] got, input [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'h1;
        @(posedge mclk);
        bus_wr <= 1'h0;
    endtask
    task rd(input [7:0] a, input [7:0] x);
        @(posedge mclk);
        rq.push_back(x);
        bus_addr <= a;
        bus_rd <= 1'h1;
        @(posedge mclk);
        bus_rd <= 1'h0;
    endtask
    task en(input [4:0] i, input [1:0] l);
        wr(8'hA2, {3'h4, i});
        wr(8'hA1, 8'h01);
        wr(8'hA5, {3'h0, i});
        wr(8'hA6, {6'h00, l});
    endtask
    task pulse(input [29:0] m);
        @(posedge mclk);
        irq_req <= m;
        @(posedge mclk);
        irq_req <= 30'h0;
    endtask
    task drain;
        int n;
        n = 0;
        while (pq.size() != 0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (pq.size() != 0) chk("pc_load missing", 16'h1, 16'h0);
    endtask
    // Opens the core for vectors; extra cycles catch unwanted takes
    task run(input p, input [4:0] i);
        if (p) pq.push_back({1'h1, 16'h0003 + {8'h00, i, 3'h0}});
        @(posedge mclk);
        stall <= 1'h0;
        drain;
        repeat (8) @(posedge mclk);
        stall <= 1'h1;
    endtask
    task ret;
        @(posedge mclk);
        pq.push_back({1'h0, rs.pop_back()});
        do_ret <= 1'h1;
        @(posedge mclk);
        do_ret <= 1'h0;
        drain;
    endtask
    task rwait;
        int n;
        n = 0;
        while (in_reset !== 1'h1 && n < 30) begin
            @(posedge mclk);
            n++;
        end
        while (in_reset !== 1'h0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk("in_reset", in_reset, 1'h0);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test;
        end
        if (rd_d) chk("bus_rdata", bus_rdata, rq.pop_front());
        rd_d <= bus_rd;
        if (in_reset === 1'h1) npc = 16'h0001;
        if (pc_load === 1'h1 && in_reset === 1'h0) begin
            e = (pq.size() != 0) ? pq.pop_front() : 17'h1FFFF;
            chk("pc_out", pc_out, e[15:0]);
            if (e[16]) rs.push_back(npc);
            npc = e[15:0] + 16'h0001;
        end
    end
    initial begin
        v = $urandom(61548);
        repeat (16) @(posedge mclk);
        sys_rst <= 1'h0;
        rd(8'h9F, 8'h00);
        rd(8'hA0, 8'hFF);
        for (int i = 0; i < 30; i++) begin
            en(i[4:0], 2'h0);
            pulse(30'h1 << i);
            run(1'h1, i[4:0]);
            ret;
        end
        wr(8'hA4, 8'h01);
        repeat (2) @(posedge mclk);
        chk("irq_out", irq_out, 1'h1);
        rd(8'hA3, 8'h01);
        repeat (3) @(posedge mclk);
        chk("irq_out", irq_out, 1'h0);
        wr(8'hA4, 8'h00);
        wr(8'hA2, 8'h06);
        pulse(30'h40);
        run(1'h0, 5'd0);
        wr(8'hA2, 8'h86);
        run(1'h1, 5'd6);
        ret;
        en(5'd2, 2'h0);
        en(5'd5, 2'h2);
        en(5'd1, 2'h2);
        en(5'd7, 2'h3);
        en(5'd4, 2'h0);
        pulse(30'h24);
        run(1'h1, 5'd5);
        pulse(30'h82);
        run(1'h1, 5'd7);
        ret;
        ret;
        run(1'h1, 5'd1);
        ret;
        pulse(30'h10);
        run(1'h1, 5'd2);
        ret;
        run(1'h1, 5'd4);
        ret;
        rd(8'hA3, 8'h01);
        chk("irq_out", irq_out, 1'h0);
        for (int k = 0; k < 2; k++) begin
            v = $urandom;
            v[7] = k[0];
            wr(8'hA0, v);
            @(posedge mclk);
            wdt_rst <= 1'h1;
            repeat (6) @(posedge mclk);
            wdt_rst <= 1'h0;
            rwait;
            chk("ram_keep", ram_keep, 1'h1);
            rd(8'h9F, {6'h00, ~v[7], 1'h0});
            rd(8'hA0, v);
        end
        wr(8'h9F, 8'h02);
        rd(8'h9F, 8'h02);
        wr(8'h9F, 8'h82);
        rwait;
        rd(8'h9F, 8'h02);
        @(posedge mclk);
        por_rst <= 1'h1;
        repeat (6) @(posedge mclk);
        chk("ram_keep", ram_keep, 1'h0);
        por_rst <= 1'h0;
        rwait;
        rd(8'hA0, 8'hFF);
        rd(8'h9F, 8'h00);
        repeat (4) @(posedge mclk);
        stop_test;
    end
endmodule // rbiv_core_tb
